// File: hw/iasc_pkg.sv
// package for the image front end sampling and clamp control block
`default_nettype none
package iasc_pkg;
  // operating modes
  typedef enum logic [1:0] {
    IASC_MODE_PIXEL = 2'b00,
    IASC_MODE_MONO  = 2'b01,
    IASC_MODE_LINE  = 2'b10
  } iasc_mode_t;

  // colour input selection
  typedef enum logic [1:0] {
    IASC_RED   = 2'b00,
    IASC_GREEN = 2'b01,
    IASC_BLUE  = 2'b10
  } iasc_colour_t;

  // output word formats
  typedef enum logic [1:0] {
    IASC_FMT_PAR14  = 2'b00,
    IASC_FMT_8P6    = 2'b01,
    IASC_FMT_7P7    = 2'b10,
    IASC_FMT_NIBBLE = 2'b11
  } iasc_fmt_t;

  // register map, word addressed
  localparam logic [3:0] IASC_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] IASC_ADDR_CLAMP  = 4'h1;
  localparam logic [3:0] IASC_ADDR_OFS_R  = 4'h2;
  localparam logic [3:0] IASC_ADDR_GAIN_R = 4'h5;
  localparam logic [3:0] IASC_ADDR_STAT   = 4'h8;
  localparam logic [3:0] IASC_ADDR_DATA   = 4'h9;

  // control register fields
  localparam int IASC_CTRL_MODE_LSB = 0;
  localparam int IASC_CTRL_SEL_LSB  = 2;
  localparam int IASC_CTRL_ACYC_BIT = 4;
  localparam int IASC_CTRL_FMT_LSB  = 5;
  // clamp register fields
  localparam int IASC_CLP_CODE_LSB  = 0;
  localparam int IASC_CLP_POS_LSB   = 4;
  localparam int IASC_CLP_INT_BIT   = 6;
  localparam int IASC_CLP_RNG_BIT   = 7;
  localparam int IASC_CLP_EXT_BIT   = 8;

  // reset values
  localparam logic [8:0] IASC_CTRL_RST  = 9'h000;
  localparam logic [8:0] IASC_CLAMP_RST = 9'h000;
  localparam logic [7:0] IASC_OFS_RST   = 8'h80;
  localparam logic [7:0] IASC_GAIN_RST  = 8'h00;

  // clamp pulse timing in master clocks after strobe
  localparam logic [2:0] IASC_CLAMP_BASE = 3'h1;
  localparam logic [2:0] IASC_CLAMP_LEN  = 3'h2;

  // one converted sample with its colour
  typedef struct packed {
    logic [13:0] word;
    logic [1:0]  colour;
  } iasc_sample_t;
endpackage
`default_nettype wire

// File: hw/iasc_top.sv
// sampling, clamp and output format control for the image front end
`default_nettype none
//
// Contract
// [R1] pixel mode samples red, green, blue together, one channel each
// [R2] pixel mode converts all three channels within one pixel period
// [R3] mono mode samples one register selected input in its own channel
// [R4] line mode routes the selected input through the red channel
// [R5] auto-cycle pulses step input and gain/offset red, green, blue, red
// [R6] line mode input sequence may also be set by register writes
// [R7] line mode powers down green and blue channels
// [R8] clamp pulse derived from master clock and pixel strobe
// [R9] clamp switch closed exactly while clamp pulse is active
// [R10] without auto-cycle the pin decides clamping per pixel
// [R11] pin level captured on clock edge inside the pixel strobe
// [R12] captured high gives clamp on next reset level, low suppresses
// [R13] two-bit position field shifts clamp pulse timing
// [R14] with auto-cycle an internal enable bit decides clamping
// [R15] clamp reference DAC code comes from four-bit voltage field
// [R16] range bit widens clamp DAC range and step
// [R17] external reference bit disables the internal clamp DAC
// [R18] each channel has own eight-bit offset and gain settings
// [R19] 14-bit result given parallel or as 8+6, 7+7, 4+4+4+2 phases
// [R20] all configuration lives in control registers written by host
// [R21] format code 00 parallel, 01 8+6, 10 7+7, 11 nibbles
// [R22] after reset auto-cycle starts at red with red gain and offset
module iasc_top
  import iasc_pkg::*;
#(
  parameter int DATA_W = 14            // converter word width
) (
  input  wire logic        core_clk,     // master clock
  input  wire logic        rst_b,        // asynchronous reset, active low
  input  wire logic        clk_en,       // freezes all state while low
  input  wire logic        pixel_sample_strobe,    // pixel strobe
  input  wire logic        clamp_or_autocycle_pin, // clamp or cycle pin
  input  wire logic [DATA_W-1:0] adc_word, // raw converter result
  input  wire logic        adc_overrange, // input over range flag
  input  wire logic [3:0]  reg_addr,     // register word address
  input  wire logic [15:0] reg_wdata,    // register write data
  input  wire logic        reg_wr,       // write strobe
  input  wire logic        reg_rd,       // read strobe
  output logic      [15:0] reg_rdata,    // read data, cycle after strobe
  output logic      [2:0]  sample_en,    // per input sample switches
  output logic      [1:0]  adc_mux,      // channel into converter
  output logic      [2:0]  chan_pwr,     // channel power enables
  output logic             internal_clamp_pulse, // clamp switch drive
  output logic      [3:0]  clamp_reference_dac, // dac code
  output logic             clamp_dac_range_select, // dac range
  output logic             dac_enable,   // internal dac enabled
  output logic      [7:0]  offset_code,  // offset for colour in use
  output logic      [7:0]  gain_code,    // gain for colour in use
  output logic      [13:0] data_out,     // formatted output pins
  output logic      [1:0]  out_phase     // current output phase
);
  // the formatter slices fixed fields, so only 14-bit words are served
  if (DATA_W != 14) begin : g_width_check
    $error("iasc_top supports 14-bit words only");
  end

  logic [8:0]  ctrl_q;
  logic [8:0]  clamp_q;
  logic [7:0]  ofs_q  [3];
  logic [7:0]  gain_q [3];
  logic [1:0]  cyc_sel_q;
  logic        strobe_q;
  logic        clamp_req_q;
  logic [2:0]  clamp_cnt_q;
  logic        clamp_run_q;
  logic        pin_q;
  logic [1:0]  conv_q;
  iasc_sample_t hold_q;
  logic        ovr_q;

  iasc_mode_t mode;
  iasc_fmt_t  fmt;
  logic       acyc_on;
  logic [1:0] cur_sel;
  logic [1:0] cur_chan;
  logic       strobe_rise;
  logic       wr_sel_line;

  assign mode    = iasc_mode_t'(ctrl_q[IASC_CTRL_MODE_LSB +: 2]);
  assign fmt     = iasc_fmt_t'(ctrl_q[IASC_CTRL_FMT_LSB +: 2]);
  assign acyc_on = ctrl_q[IASC_CTRL_ACYC_BIT] && (mode == IASC_MODE_LINE);
  // auto-cycle state overrides the register choice in line mode
  assign cur_sel = acyc_on ? cyc_sel_q : ctrl_q[IASC_CTRL_SEL_LSB +: 2];
  // line mode always uses the red channel
  assign cur_chan = (mode == IASC_MODE_LINE) ? 2'(IASC_RED) : // R4
                    (mode == IASC_MODE_PIXEL) ? conv_q : cur_sel;
  assign strobe_rise = pixel_sample_strobe && !strobe_q;
  assign wr_sel_line = reg_wr && (reg_addr == IASC_ADDR_CTRL);

  // colour decode used for sample switches and channel power enables
  function automatic logic [2:0] onehot(input logic [1:0] c);
    case (c)
      2'(IASC_RED):   onehot = 3'h1;
      2'(IASC_GREEN): onehot = 3'h2;
      2'(IASC_BLUE):  onehot = 3'h4;
      default:        onehot = 3'h1;
    endcase
  endfunction

  // next colour in the red, green, blue sequence
  function automatic logic [1:0] next_colour(input logic [1:0] c);
    next_colour = (c == 2'(IASC_BLUE)) ? 2'(IASC_RED) : c + 2'h1;
  endfunction

  // configuration registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q  <= IASC_CTRL_RST;
      clamp_q <= IASC_CLAMP_RST;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == IASC_ADDR_CTRL) begin
        ctrl_q <= reg_wdata[8:0]; // R20
      end else if (reg_addr == IASC_ADDR_CLAMP) begin
        clamp_q <= reg_wdata[8:0]; // R20
      end
    end
  end

  // per channel offset and gain settings
  for (genvar i = 0; i < 3; i++) begin : g_chan
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        ofs_q[i]  <= IASC_OFS_RST;
        gain_q[i] <= IASC_GAIN_RST;
      end else if (clk_en && reg_wr) begin
        if (reg_addr == IASC_ADDR_OFS_R + 4'(i)) begin
          ofs_q[i] <= reg_wdata[7:0]; // R18
        end else if (reg_addr == IASC_ADDR_GAIN_R + 4'(i)) begin
          gain_q[i] <= reg_wdata[7:0]; // R18
        end
      end
    end
  end

  // auto-cycle colour pointer, reset to red
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_sel_q <= 2'(IASC_RED); // R22
    end else if (clk_en) begin
      if (wr_sel_line) begin
        cyc_sel_q <= reg_wdata[IASC_CTRL_SEL_LSB +: 2]; // R6
      end else if (acyc_on && strobe_rise && clamp_or_autocycle_pin) begin
        cyc_sel_q <= next_colour(cyc_sel_q); // R5
      end
    end
  end

  // strobe edge tracking and pin capture during the strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_q    <= 1'b0;
      clamp_req_q <= 1'b0;
    end else if (clk_en) begin
      strobe_q <= pixel_sample_strobe;
      if (strobe_rise) begin
        if (acyc_on) begin
          clamp_req_q <= clamp_q[IASC_CLP_INT_BIT]; // R14
        end else begin
          clamp_req_q <= clamp_or_autocycle_pin; // R10 R11
        end
      end
    end
  end

  // clamp pulse placed by the position field after the strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clamp_cnt_q <= 3'h0;
      clamp_run_q <= 1'b0;
      pin_q       <= 1'b0;
    end else if (clk_en) begin
      if (strobe_rise) begin
        clamp_cnt_q <= 3'h0; // R8
        clamp_run_q <= 1'b1;
      end else if (clamp_run_q) begin
        clamp_cnt_q <= clamp_cnt_q + 3'h1;
        if (clamp_cnt_q == 3'h7) begin
          clamp_run_q <= 1'b0;
        end
      end
      // pulse window: base plus position, fixed length
      pin_q <= clamp_run_q && clamp_req_q &&
               (clamp_cnt_q >= IASC_CLAMP_BASE +
                  {1'b0, clamp_q[IASC_CLP_POS_LSB +: 2]}) && // R13
               (clamp_cnt_q < IASC_CLAMP_BASE + IASC_CLAMP_LEN +
                  {1'b0, clamp_q[IASC_CLP_POS_LSB +: 2]}); // R12
    end
  end

  // converter channel sequence, three slots per pixel in pixel mode
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_q <= 2'(IASC_RED);
    end else if (clk_en) begin
      if (strobe_rise || mode != IASC_MODE_PIXEL) begin
        conv_q <= 2'(IASC_RED); // R2
      end else if (conv_q != 2'(IASC_BLUE)) begin
        conv_q <= next_colour(conv_q); // R2
      end
    end
  end

  // analogue path controls
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_en              <= 3'h0;
      adc_mux                <= 2'h0;
      chan_pwr               <= 3'h0;
      internal_clamp_pulse   <= 1'b0;
      clamp_reference_dac    <= 4'h0;
      clamp_dac_range_select <= 1'b0;
      dac_enable             <= 1'b0;
      offset_code            <= IASC_OFS_RST;
      gain_code              <= IASC_GAIN_RST;
    end else if (clk_en) begin
      case (mode)
        IASC_MODE_PIXEL: begin
          sample_en <= 3'h7; // R1
          chan_pwr  <= 3'h7;
        end
        IASC_MODE_MONO: begin
          sample_en <= onehot(cur_sel); // R3
          chan_pwr  <= onehot(cur_sel);
        end
        default: begin
          sample_en <= onehot(cur_sel); // R4
          chan_pwr  <= 3'h1; // R7
        end
      endcase
      adc_mux              <= cur_chan;
      internal_clamp_pulse <= pin_q; // R9
      clamp_reference_dac  <= clamp_q[IASC_CLP_CODE_LSB +: 4]; // R15
      clamp_dac_range_select <= clamp_q[IASC_CLP_RNG_BIT]; // R16
      dac_enable           <= !clamp_q[IASC_CLP_EXT_BIT]; // R17
      // line mode takes settings of the selected colour
      offset_code <= ofs_q[(mode == IASC_MODE_LINE) ? cur_sel : cur_chan];
      gain_code   <= gain_q[(mode == IASC_MODE_LINE) ? cur_sel : cur_chan];
    end
  end

  // capture each result and step the output phases
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q    <= '0;
      ovr_q     <= 1'b0;
      out_phase <= 2'h0;
    end else if (clk_en) begin
      if (out_phase == 2'h0) begin
        hold_q.word   <= adc_word;
        hold_q.colour <= (mode == IASC_MODE_PIXEL) ? conv_q : cur_sel;
        ovr_q         <= adc_overrange;
      end
      case (fmt)
        IASC_FMT_PAR14:  out_phase <= 2'h0;
        IASC_FMT_NIBBLE: out_phase <= out_phase + 2'h1;
        default:         out_phase <= {1'b0, ~out_phase[0]};
      endcase
    end
  end

  // output word formatting, flag bit marks green
  logic cc;
  assign cc = (hold_q.colour == 2'(IASC_GREEN));
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_out <= 14'h0000;
    end else if (clk_en) begin
      case (fmt)
        IASC_FMT_PAR14: data_out <= adc_word; // R19 R21
        IASC_FMT_8P6: begin
          data_out <= (out_phase == 2'h0) ?
            {hold_q.word[13:6], 6'h00} :
            {hold_q.word[5:0], cc, ovr_q, 6'h00}; // R19 R21
        end
        IASC_FMT_7P7: begin
          data_out <= (out_phase == 2'h0) ?
            {hold_q.word[13:7], cc, 6'h00} :
            {hold_q.word[6:0], ovr_q, 6'h00}; // R21
        end
        default: begin
          case (out_phase)
            2'h0: data_out <= {hold_q.word[13:10], 10'h000}; // R21
            2'h1: data_out <= {hold_q.word[9:6], 10'h000};
            2'h2: data_out <= {hold_q.word[5:2], 10'h000};
            default: data_out <= {hold_q.word[1:0], cc, ovr_q, 10'h000};
          endcase
        end
      endcase
    end
  end

  // register read port
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      if (!reg_rd) begin
        reg_rdata <= 16'h0000;
      end else if (reg_addr == IASC_ADDR_CTRL) begin
        reg_rdata <= {7'h00, ctrl_q};
      end else if (reg_addr == IASC_ADDR_CLAMP) begin
        reg_rdata <= {7'h00, clamp_q};
      end else if (reg_addr >= IASC_ADDR_OFS_R &&
                   reg_addr < IASC_ADDR_GAIN_R) begin
        reg_rdata <= {8'h00, ofs_q[2'(reg_addr - IASC_ADDR_OFS_R)]};
      end else if (reg_addr >= IASC_ADDR_GAIN_R &&
                   reg_addr < IASC_ADDR_STAT) begin
        reg_rdata <= {8'h00, gain_q[2'(reg_addr - IASC_ADDR_GAIN_R)]};
      end else if (reg_addr == IASC_ADDR_STAT) begin
        reg_rdata <= {11'h000, clamp_req_q, cyc_sel_q, cur_chan};
      end else if (reg_addr == IASC_ADDR_DATA) begin
        reg_rdata <= {2'h0, hold_q.word};
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/iasc_scan_ctl.sv
// scanner controller model driving the strobe and clamp pin
`default_nettype none
module iasc_scan_ctl (
  input  wire logic core_clk,              // master clock
  output var logic  pixel_sample_strobe,   // pixel strobe
  output var logic  clamp_or_autocycle_pin // clamp or cycle pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle levels
  initial begin
    pixel_sample_strobe = 1'b0;
    clamp_or_autocycle_pin = 1'b0;
  end
  // one pixel: pin set up, strobe two clocks, then the pin hold ends
  task automatic pixel(input logic lvl, input int wait_n);
    @(posedge core_clk);
    clamp_or_autocycle_pin <= lvl;
    repeat (wait_n) @(posedge core_clk);
    pixel_sample_strobe <= 1'b1;
    repeat (2) @(posedge core_clk);
    pixel_sample_strobe <= 1'b0;
    clamp_or_autocycle_pin <= ~lvl; // hold over, show the opposite
    repeat (10) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// File: verification/iasc_checker.sv
// assertions on the ports of the sampling and clamp block
`default_nettype none
module iasc_checker
  import iasc_pkg::*;
(
  input wire logic        core_clk,            // master clock
  input wire logic        rst_b,               // reset, active low
  input wire logic        clk_en,              // run enable
  input wire logic        pixel_sample_strobe, // pixel strobe
  input wire logic        reg_rd,              // read strobe
  input wire logic [15:0] reg_rdata,           // read data
  input wire logic [2:0]  sample_en,           // input switches
  input wire logic [1:0]  adc_mux,             // converter channel
  input wire logic [2:0]  chan_pwr,            // channel power
  input wire logic        internal_clamp_pulse // clamp drive
);
  logic [3:0] since_q; // age of the current pixel
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // saturating count of clocks since the strobe rose
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) since_q <= 4'hf;
    else if ($rose(pixel_sample_strobe)) since_q <= 4'h0;
    else if (since_q != 4'hf) since_q <= since_q + 4'h1;
  end
  sequence s_rise;
    $rose(pixel_sample_strobe);
  endsequence
  sequence s_rgb;
    adc_mux == 2'h0 ##1 adc_mux == 2'h1 ##1 adc_mux == 2'h2;
  endsequence
  chk_clamp_width: assert property (
    $rose(internal_clamp_pulse) |=> internal_clamp_pulse ##1
    !internal_clamp_pulse) else $error("clamp pulse not two clocks");
  chk_clamp_cause: assert property (
    $rose(internal_clamp_pulse) |-> since_q inside {[4'h1:4'h7]})
    else $error("clamp pulse without a pixel");
  chk_read_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  chk_sample_set: assert property (
    sample_en == 3'h7 || $onehot0(sample_en))
    else $error("bad input switch set");
  chk_pixel_order: assert property (
    s_rise ##1 sample_en == 3'h7 |-> ##[0:1] s_rgb)
    else $error("pixel conversion order wrong");
  chk_line_mux: assert property (
    s_rise ##3 chan_pwr == 3'h1 |-> adc_mux == 2'h0)
    else $error("single channel not red");
  chk_line_one: assert property (
    s_rise ##3 chan_pwr == 3'h1 |-> $onehot(sample_en))
    else $error("single channel samples several inputs");
  chk_freeze_hold: assert property (
    !clk_en |=> $stable({sample_en, adc_mux, chan_pwr,
    internal_clamp_pulse})) else $error("state moved while frozen");
endmodule
bind iasc_top iasc_checker u_chk (
  .core_clk, .rst_b, .clk_en, .pixel_sample_strobe, .reg_rd, .reg_rdata,
  .sample_en, .adc_mux, .chan_pwr, .internal_clamp_pulse
);
`default_nettype wire

// File: verification/test_iasc.sv
// self-checking bench for the sampling and clamp block
`default_nettype none
module test_image_afe_sampling_clamp_control
  import iasc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, rst_b, clk_en, strobe, pin, reg_wr, reg_rd;
  logic        ovr, pulse, rng, dac_en, str_d, pls_d;
  logic [13:0] adc_word, data_out;
  logic [3:0]  reg_addr, dac;
  logic [15:0] reg_wdata, reg_rdata;
  logic [2:0]  sample_en, chan_pwr;
  logic [1:0]  adc_mux, out_phase;
  logic [7:0]  offset_code, gain_code;
  int          cyc, rise_c, pls_c, hi_n, error_cnt, cmp_count;
  iasc_top u_dut (.core_clk, .rst_b, .clk_en, .pixel_sample_strobe(strobe),
    .clamp_or_autocycle_pin(pin), .adc_word, .adc_overrange(ovr),
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sample_en,
    .adc_mux, .chan_pwr, .internal_clamp_pulse(pulse),
    .clamp_reference_dac(dac), .clamp_dac_range_select(rng),
    .dac_enable(dac_en), .offset_code, .gain_code, .data_out, .out_phase);
  iasc_scan_ctl u_ctl (.core_clk, .pixel_sample_strobe(strobe),
    .clamp_or_autocycle_pin(pin));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // pixel and clamp timing monitor, plus hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (strobe && !str_d) rise_c = cyc;
    if (pulse && !pls_d) pls_c = cyc;
    if (pulse) hi_n++;
    str_d = strobe;
    pls_d = pulse;
    if (cyc > 3000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic check(input logic [15:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk) reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] e, string w);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk) reg_rd <= 1'b0;
    #1 check(reg_rdata, e, w);
  endtask
  function automatic logic [15:0] ctl(iasc_mode_t m, iasc_colour_t s,
                                      logic ac, iasc_fmt_t f);
    return {9'h0, f, ac, s, m};
  endfunction
  task automatic t_reg();
    check(16'(offset_code), 16'h80, "ofs rst");
    @(posedge core_clk) clk_en <= 1'b0;
    repeat (3) @(posedge core_clk);
    clk_en <= 1'b1;
    rchk(IASC_ADDR_STAT, 16'h0002, "cyc rst");
    for (int i = 0; i < 3; i++) begin
      wr(IASC_ADDR_OFS_R + 4'(i), 16'h10 + 16'(i));
      wr(IASC_ADDR_GAIN_R + 4'(i), 16'h40 + 16'(i));
    end
    for (int i = 0; i < 3; i++) begin
      rchk(IASC_ADDR_OFS_R + 4'(i), 16'h10 + 16'(i), "ofs");
      rchk(IASC_ADDR_GAIN_R + 4'(i), 16'h40 + 16'(i), "gain");
    end
    rchk(4'hf, 16'h0, "unmapped");
    wr(IASC_ADDR_CLAMP, 16'h00ba);
    rchk(IASC_ADDR_CLAMP, 16'h00ba, "clamp rb");
    check({dac, 11'h0, rng}, 16'ha001, "dac code");
    check(16'(dac_en), 16'h1, "dac on");
    wr(IASC_ADDR_CLAMP, 16'h0100);
    rchk(IASC_ADDR_CLAMP, 16'h0100, "clamp rb2");
    check(16'({dac_en, rng}), 16'h0, "dac off");
    $display("registers done");
  endtask
  task automatic t_mode();
    wr(IASC_ADDR_CTRL, ctl(IASC_MODE_PIXEL, IASC_RED, 0, IASC_FMT_PAR14));
    u_ctl.pixel(1'b0, 0);
    check(16'({sample_en, chan_pwr}), 16'h3f, "pixel");
    wr(IASC_ADDR_CTRL, ctl(IASC_MODE_MONO, IASC_GREEN, 0, IASC_FMT_PAR14));
    u_ctl.pixel(1'b0, 2);
    check({sample_en, adc_mux, 3'h0, offset_code}, 16'h4811, "mono");
    check(16'(gain_code), 16'h41, "mono gain");
    wr(IASC_ADDR_CTRL, ctl(IASC_MODE_LINE, IASC_BLUE, 0, IASC_FMT_PAR14));
    u_ctl.pixel(1'b0, 0);
    check(16'({sample_en, chan_pwr, adc_mux}), 16'h0084, "line");
    $display("modes done");
  endtask
  task automatic t_clamp();
    int d0;
    wr(IASC_ADDR_CTRL, ctl(IASC_MODE_PIXEL, IASC_RED, 0, IASC_FMT_PAR14));
    for (int p = 0; p < 4; p++) begin
      wr(IASC_ADDR_CLAMP, {10'h0, 2'(p), 4'h0});
      hi_n = 0;
      pls_c = 0;
      u_ctl.pixel(1'b1, p);
      if (p == 0) d0 = pls_c - rise_c;
      check(16'(pls_c - rise_c - d0), 16'(p), "clamp pos");
      check(16'(hi_n), 16'(IASC_CLAMP_LEN), "clamp len");
      check(16'(d0 > 1 && d0 < 7), 16'h1, "clamp start");
      hi_n = 0;
      u_ctl.pixel(1'b0, 0);
      check(16'(hi_n), 16'h0, "clamp skip");
    end
    $display("clamp done");
  endtask
  task automatic t_acyc();
    wr(IASC_ADDR_CLAMP, 16'h0040);
    wr(IASC_ADDR_CTRL, ctl(IASC_MODE_LINE, IASC_RED, 1, IASC_FMT_PAR14));
    for (int i = 1; i < 5; i++) begin
      hi_n = 0;
      u_ctl.pixel(1'b1, 1);
      check(16'(sample_en), 16'(1 << (i % 3)), "cyc in");
      check({offset_code, gain_code}, 16'h1040 + 16'h0101 * 16'(i % 3),
            "cyc set");
      check(16'(hi_n), 16'(IASC_CLAMP_LEN), "int clamp");
    end
    wr(IASC_ADDR_CLAMP, 16'h0000);
    hi_n = 0;
    u_ctl.pixel(1'b1, 0);
    check({sample_en, 5'h0, hi_n[7:0]}, 16'h8000, "int off");
    u_ctl.pixel(1'b0, 0);
    check(16'(sample_en), 16'h4, "cyc hold");
    wr(IASC_ADDR_CTRL, ctl(IASC_MODE_LINE, IASC_GREEN, 1, IASC_FMT_PAR14));
    u_ctl.pixel(1'b0, 0);
    check(16'(sample_en), 16'h2, "reg sel");
    $display("autocycle done");
  endtask
  task automatic t_fmt();
    logic [13:0] w;
    logic [7:0]  ea [4];
    logic [7:0]  ez [4];
    logic        fa, fz;
    w = adc_word;
    ea = '{8'h0, w[13:6], {w[13:7], 1'b0}, {w[13:10], 4'h0}};
    ez = '{8'h0, {w[5:0], 2'b01}, {w[6:0], 1'b1}, {w[1:0], 2'b01, 4'h0}};
    wr(IASC_ADDR_CTRL, ctl(IASC_MODE_MONO, IASC_RED, 0, IASC_FMT_PAR14));
    u_ctl.pixel(1'b0, 0);
    check(16'(data_out), 16'(w), "parallel");
    check(16'(out_phase), 16'h0, "phase par");
    for (int f = 1; f < 4; f++) begin
      wr(IASC_ADDR_CTRL, ctl(IASC_MODE_MONO, IASC_RED, 0, iasc_fmt_t'(f)));
      fa = 1'b0;
      fz = 1'b0;
      fork
        u_ctl.pixel(1'b0, 0);
        repeat (14) begin
          @(posedge core_clk);
          #1 if ((data_out[13:6] & (f == 3 ? 8'hf0 : 8'hff)) === ea[f])
            fa = 1'b1;
          if ((data_out[13:6] & (f == 3 ? 8'hf0 : 8'hff)) === ez[f])
            fz = 1'b1;
        end
      join
      check(16'({fa, fz}), 16'h3, "mux pieces");
    end
    $display("formats done");
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    {rst_b, reg_wr, reg_rd, str_d, pls_d} = '0;
    clk_en = 1'b1;
    ovr = 1'b1;
    adc_word = 14'h2b5c;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reg();
    t_mode();
    t_clamp();
    t_acyc();
    t_fmt();
    summarize();
  end
endmodule
`default_nettype wire
